// >>> verilog/counter_array_pkg.sv
// Constants and types of the wide PWM module.
// Assumes a 32-bit Avalon-MM slave port.
package counter_array_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CMP_LOW = 5'h00;
  localparam logic [4:0] OFS_CMP_HIGH = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_CONFIG = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_COUNTER = 5'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_RUN_BIT = 4;
  localparam int CFG_OVF_BIT = 5;
  localparam int CFG_RELOAD_REGISTER_SELECT_BIT = 7;
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_8BIT = 2'h0;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_9BIT = 2'h1;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_10BIT = 2'h2;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_11BIT = 2'h3;
  localparam logic [11:0] PERIOD_8BIT = 12'h100;
  localparam logic [11:0] PERIOD_9BIT = 12'h200;
  localparam logic [11:0] PERIOD_10BIT = 12'h400;
  localparam logic [11:0] PERIOD_11BIT = 12'h800;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_e;
  typedef struct packed {
    logic comparator_enable;
    logic match_flag_enable;
    logic pwm_enable;
  } mode_s;
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_s;
endpackage

// >>> verilog/counter_array_wide_pwm.sv
// One 9/10/11-bit PWM compare module with
// its own counter and register slave.
// Assumes an aligned 32-bit Avalon master.
//
// Notes on behaviour
// - Shadow reload register shares compare bytes
// - Select bit picks shadow or active
// - Counter low bits equal compare: high
// - N-bit overflow drives output low
// - Overflow sets flag, reloads compare
// - Cycle length follows length select
// - Mode needs enables and length above 8
// - Match sets match flag when enabled
// - Overflow every 512, 1024, 2048 clocks
// - Low write clears, high sets enable
// - Duty is (2^N minus compare)/2^N
// - Comparator disabled keeps output low
`timescale 1ns/100ps
module counter_array_wide_pwm
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pin
  output logic waveform_output
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  avmm_req_s req;
  bus_state_e bus_state_reg;
  logic [31:0] read_value;
  logic [31:0] readdata_reg;
  logic [4:0] word_addr;
  logic answer;
  logic wr_accept;
  logic wr_low;
  logic wr_high;
  logic wr_mode;
  logic wr_config;
  logic wr_status;
  logic [7:0] wdata_byte;

  // Bundle of the request lines
  assign req = {read, write, address, byteenable, writedata};
  assign word_addr = {req.address[ADDR_W-1:2], 2'b00};
  assign answer = bus_state_reg == BUS_ANSWER;
  // One wait cycle gives a registered read
  assign waitrequest = (req.read | req.write) & ~answer;
  assign wr_accept = req.write & answer & req.byteenable[0];
  assign wdata_byte = req.writedata[7:0];
  assign wr_low = wr_accept & (word_addr == OFS_CMP_LOW);
  assign wr_high = wr_accept & (word_addr == OFS_CMP_HIGH);
  assign wr_mode = wr_accept & (word_addr == OFS_MODE);
  assign wr_config = wr_accept & (word_addr == OFS_CONFIG);
  assign wr_status = wr_accept & (word_addr == OFS_STATUS);
  assign readdata = readdata_reg;

  // Answer state, one cycle per access
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (req.read | req.write) begin
            bus_state_reg <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers and counter state
  // ----------------------------------------
  mode_s mode_reg;
  logic [15:0] cmp_reg;
  logic [15:0] shadow_reg;
  logic [15:0] cnt_reg;
  logic [1:0] cycle_length_select_reg;
  logic run_reg;
  logic reload_register_select_reg;
  logic ovf_flag_reg;
  logic match_flag_reg;
  logic out_reg;
  logic [10:0] mask;
  logic [15:0] cnt_next;
  logic [10:0] target;
  logic wide_sel;
  logic wide_mode;
  logic overflow;
  logic reload;
  logic match;

  // Read mux, unmapped reads give zero
  always_comb begin
    read_value = 32'h00000000;
    unique case (word_addr)
      OFS_CMP_LOW: read_value[7:0] = reload_register_select_reg ? shadow_reg[7:0] : cmp_reg[7:0];
      OFS_CMP_HIGH: read_value[7:0] = reload_register_select_reg ? shadow_reg[15:8] : cmp_reg[15:8];
      OFS_MODE: read_value[2:0] = mode_reg;
      OFS_CONFIG: begin
        read_value[1:0] = cycle_length_select_reg;
        read_value[CFG_RUN_BIT] = run_reg;
        read_value[CFG_OVF_BIT] = ovf_flag_reg;
        read_value[CFG_RELOAD_REGISTER_SELECT_BIT] = reload_register_select_reg;
      end
      OFS_STATUS: begin
        read_value[STAT_MATCH_BIT] = match_flag_reg;
        read_value[STAT_OUT_BIT] = out_reg;
      end
      OFS_COUNTER: read_value[15:0] = cnt_reg;
      default: read_value = 32'h00000000;
    endcase
  end

  // Read data caught on the request edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= 32'h00000000;
    end else if ((req.read | req.write) & ~answer) begin
      readdata_reg <= read_value;
    end
  end

  // Cycle mask for the selected length
  always_comb begin
    unique case (cycle_length_select_reg)
      CYCLE_LENGTH_SELECT_8BIT: mask = 11'h0FF;
      CYCLE_LENGTH_SELECT_9BIT: mask = 11'h1FF;
      CYCLE_LENGTH_SELECT_10BIT: mask = 11'h3FF;
      CYCLE_LENGTH_SELECT_11BIT: mask = 11'h7FF;
    endcase
  end

  // Compare and overflow decode
  assign wide_sel = mode_reg.pwm_enable & (cycle_length_select_reg != CYCLE_LENGTH_SELECT_8BIT);
  assign wide_mode = wide_sel & mode_reg.comparator_enable;
  assign cnt_next = cnt_reg + 16'h0001;
  assign overflow = run_reg & ((cnt_reg[10:0] & mask) == mask);
  assign reload = overflow & wide_sel;
  // Compare against the value loaded at this same wrap
  assign target = (reload ? shadow_reg[10:0] : cmp_reg[10:0]) & mask;
  assign match = run_reg & wide_mode & ((cnt_next[10:0] & mask) == target);

  // Counter, free running while enabled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= CNT_RESET;
    end else if (run_reg) begin
      cnt_reg <= cnt_next;
    end
  end

  // Mode bits; compare byte writes move the enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wdata_byte[2:0];
    end else if (wr_low) begin
      mode_reg.comparator_enable <= 1'b0;
    end else if (wr_high) begin
      mode_reg.comparator_enable <= 1'b1;
    end
  end

  // Configuration bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cycle_length_select_reg <= CYCLE_LENGTH_SELECT_8BIT;
      run_reg <= 1'b0;
      reload_register_select_reg <= 1'b0;
    end else if (wr_config) begin
      cycle_length_select_reg <= wdata_byte[1:0];
      run_reg <= wdata_byte[CFG_RUN_BIT];
      reload_register_select_reg <= wdata_byte[CFG_RELOAD_REGISTER_SELECT_BIT];
    end
  end

  // Shadow register, written only when selected
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shadow_reg <= CMP_RESET;
    end else if (reload_register_select_reg & wr_low) begin
      shadow_reg[7:0] <= wdata_byte;
    end else if (reload_register_select_reg & wr_high) begin
      shadow_reg[15:8] <= wdata_byte;
    end
  end

  // Active compare: reload first, software byte on top
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmp_reg <= CMP_RESET;
    end else begin
      if (reload) begin
        cmp_reg <= shadow_reg;
      end
      if (!reload_register_select_reg & wr_low) begin
        cmp_reg[7:0] <= wdata_byte;
      end
      if (!reload_register_select_reg & wr_high) begin
        cmp_reg[15:8] <= wdata_byte;
      end
    end
  end

  // Flags, a set beats a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovf_flag_reg <= 1'b0;
      match_flag_reg <= 1'b0;
    end else begin
      if (reload) begin
        ovf_flag_reg <= 1'b1;
      end else if (wr_config & ~wdata_byte[CFG_OVF_BIT]) begin
        ovf_flag_reg <= 1'b0;
      end
      if (match & mode_reg.match_flag_enable) begin
        match_flag_reg <= 1'b1;
      end else if (wr_status & ~wdata_byte[STAT_MATCH_BIT]) begin
        match_flag_reg <= 1'b0;
      end
    end
  end

  // Output: high from match to wrap, match wins at 0
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_reg <= 1'b0;
    end else if (!wide_mode) begin
      out_reg <= 1'b0;
    end else if (match) begin
      out_reg <= 1'b1;
    end else if (overflow) begin
      out_reg <= 1'b0;
    end
  end
  assign waveform_output = out_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [11:0] gap_reg;
  logic stable_reg;
  logic [11:0] period;
  logic ecom;

  assign ecom = mode_reg.comparator_enable;
  assign period = (cycle_length_select_reg == CYCLE_LENGTH_SELECT_9BIT) ? PERIOD_9BIT :
                  (cycle_length_select_reg == CYCLE_LENGTH_SELECT_10BIT) ? PERIOD_10BIT :
                  (cycle_length_select_reg == CYCLE_LENGTH_SELECT_11BIT) ? PERIOD_11BIT : PERIOD_8BIT;

  // Cycles since the last wrap, valid while settings stand
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 12'h000;
      stable_reg <= 1'b0;
    end else begin
      gap_reg <= overflow ? 12'h000 : gap_reg + 12'h001;
      if (!run_reg | wr_config) begin
        stable_reg <= 1'b0;
      end else if (overflow) begin
        stable_reg <= 1'b1;
      end
    end
  end

  property p_period;
    @(posedge clock) disable iff (!resetn)
    overflow & stable_reg & ~wr_config |-> gap_reg == period - 12'h001;
  endproperty
  a_period: assert property (p_period) else $error("wrap period wrong");
  property p_match_high;
    @(posedge clock) disable iff (!resetn)
    match |=> waveform_output;
  endproperty
  a_match_high: assert property (p_match_high) else $error("match not high");
  property p_wrap_low;
    @(posedge clock) disable iff (!resetn)
    overflow & ~match |=> !waveform_output;
  endproperty
  a_wrap_low: assert property (p_wrap_low) else $error("wrap not low");
  property p_reload;
    @(posedge clock) disable iff (!resetn)
    reload & ~wr_low & ~wr_high |=> cmp_reg == $past(shadow_reg) && ovf_flag_reg;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_low_clears;
    @(posedge clock) disable iff (!resetn)
    wr_low |=> !ecom ##1 !waveform_output;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("enable kept");
  property p_high_sets;
    @(posedge clock) disable iff (!resetn)
    wr_high |=> ecom;
  endproperty
  a_high_sets: assert property (p_high_sets) else $error("enable not set");
  property p_off_low;
    @(posedge clock) disable iff (!resetn)
    !ecom & $past(!ecom) |-> !waveform_output;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high");
  property p_match_flag;
    @(posedge clock) disable iff (!resetn)
    match & mode_reg.match_flag_enable |=> match_flag_reg;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("no match flag");
  property p_shadow_sel;
    @(posedge clock) disable iff (!resetn)
    wr_low & reload_register_select_reg & ~reload |=> shadow_reg[7:0] == $past(wdata_byte) && $stable(cmp_reg);
  endproperty
  a_shadow_sel: assert property (p_shadow_sel) else $error("wrong target");
  property p_mode_gate;
    @(posedge clock) disable iff (!resetn)
    !wide_mode |=> !waveform_output;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("mode off high");

endmodule

// >>> verification/pwm_load_model.sv
// Load model on the waveform pin: measures every PWM period.
// Assumes the pin is sampled on the bench clock.
`timescale 1ns/100ps
module pwm_load_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Observed pin
  input wire logic waveform_output,
  // Measurements
  output int period_last,
  output int high_last,
  output int fall_count,
  output int high_total
);
  logic prev_reg;
  int run_cnt;
  int high_cnt;
  // Latch period and high time at each fall; a load has no say in timing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= 1'b0;
      run_cnt <= 0;
      high_cnt <= 0;
      period_last <= 0;
      high_last <= 0;
      fall_count <= 0;
      high_total <= 0;
    end else begin
      prev_reg <= waveform_output;
      high_total <= high_total + int'(waveform_output);
      if (prev_reg && !waveform_output) begin
        period_last <= run_cnt;
        high_last <= high_cnt;
        fall_count <= fall_count + 1;
        run_cnt <= 1;
        high_cnt <= 0;
      end else begin
        run_cnt <= run_cnt + 1;
        high_cnt <= high_cnt + int'(waveform_output);
      end
    end
  end
endmodule

// >>> verification/counter_array_wide_pwm_bench.sv
// Self-checking bench of the wide PWM module.
// Assumes an Avalon slave that may insert any number of wait states.
`timescale 1ns/100ps
module counter_array_wide_pwm_bench import counter_array_pkg::*;;
  logic clock;
  logic resetn;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic waveform_output;
  int period_last;
  int high_last;
  int fall_count;
  int high_total;
  int bad_count;
  int samples_checked;
  int cycles;
  logic [31:0] d;
  logic [31:0] c0;
  // ----------------------------------------
  // Design and load
  // ----------------------------------------
  counter_array_wide_pwm dut_u (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .waveform_output(waveform_output));
  pwm_load_model load_u (.clock(clock), .resetn(resetn), .waveform_output(waveform_output),
    .period_last(period_last), .high_last(high_last), .fall_count(fall_count), .high_total(high_total));
  // Clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard, well above the longest sequence
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; held until waitrequest is seen low, then an idle cycle
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= wd;
    @(posedge clock);
    // Design outputs move by NBA, so these are the values before the edge
    while (waitrequest !== 1'b0) @(posedge clock);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    bus(1'b0, a, v);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    chk(d, exp);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] sel, input logic run, input logic shadow);
    return 32'(sel) | (32'(run) << CFG_RUN_BIT) | (32'(shadow) << CFG_RELOAD_REGISTER_SELECT_BIT);
  endfunction
  task automatic wait_falls(input int n);
    int t;
    t = fall_count + n;
    while (fall_count < t) @(posedge clock);
  endtask
  // Output must not rise over n cycles
  task automatic still_low(input int n);
    repeat (4) @(posedge clock);
    c0 = high_total;
    repeat (n) @(posedge clock);
    chk(high_total - c0, 32'h0);
  endtask
  // Load a compare through the shadow, then measure a full period
  task automatic run_len(input logic [1:0] sel);
    logic [31:0] per;
    logic [15:0] cmp;
    per = 32'h100 << sel;
    cmp = 16'(per >> 1) + 16'(sel);
    wr(OFS_CONFIG, cfg(sel, 1'b1, 1'b1));
    wr(OFS_CMP_LOW, 32'(cmp[7:0]));
    rd(OFS_MODE, 32'h3);
    wr(OFS_CMP_HIGH, 32'(cmp[15:8]));
    rd(OFS_MODE, 32'h7);
    rd(OFS_CMP_HIGH, 32'(cmp[15:8]));
    wr(OFS_CONFIG, cfg(sel, 1'b1, 1'b0));
    wr(OFS_STATUS, 32'h0);
    wait_falls(3);
    chk(period_last, per);
    chk(high_last, per - 32'(cmp));
    rd(OFS_CMP_LOW, 32'(cmp[7:0]));
    rd(OFS_CONFIG, cfg(sel, 1'b1, 1'b0) | 32'h20);
    bus(1'b1, OFS_STATUS, 32'h0);
    chk(d & 32'h1, 32'h1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    byteenable = 4'hF;
    writedata = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    // Reset values, unmapped words included
    for (int a = 0; a < 32; a += 4) rd(5'(a), 32'h0);
    wr(5'h18, 32'hFF);
    rd(5'h18, 32'h0);
    // Shadow and active kept apart while the counter is stopped
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 1'b1));
    wr(OFS_CMP_LOW, 32'h55);
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 1'b0));
    wr(OFS_CMP_LOW, 32'hAA);
    byteenable <= 4'hE;
    wr(OFS_CMP_LOW, 32'h33);
    byteenable <= 4'hF;
    rd(OFS_CMP_LOW, 32'hAA);
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 1'b1));
    rd(OFS_CMP_LOW, 32'h55);
    // Counter steps once a clock; reads are latched three cycles apart
    wr(OFS_CONFIG, cfg(CYCLE_LENGTH_SELECT_9BIT, 1'b1, 1'b0));
    bus(1'b1, OFS_COUNTER, 32'h0);
    c0 = d;
    bus(1'b1, OFS_COUNTER, 32'h0);
    chk(d - c0, 32'h3);
    wr(OFS_MODE, 32'h7);
    for (int i = 1; i < 4; i++) run_len(2'(i));
    // Match flag stays clear once its enable is off
    wr(OFS_MODE, 32'h5);
    wr(OFS_STATUS, 32'h0);
    wait_falls(2);
    bus(1'b1, OFS_STATUS, 32'h0);
    chk(d & 32'h1, 32'h0);
    // Low byte alone leaves the comparator off: 0% duty
    wr(OFS_CMP_LOW, 32'h0);
    still_low(2100);
    // Compare 0x0003 in 8-bit length, low byte reloaded from the shadow: wide mode not in effect
    wr(OFS_CONFIG, cfg(CYCLE_LENGTH_SELECT_8BIT, 1'b1, 1'b0));
    wr(OFS_CMP_HIGH, 32'h0);
    still_low(600);
    tally_and_finish();
  end
endmodule
